// ### gst_pkg.sv
// Shared constants and types of the gated sixteen-bit timer
`default_nettype none
package gst_pkg;
	localparam int GST_ADDR_W = 3;
	localparam int GST_DATA_W = 8;
	localparam int GST_COUNT_W = 16;

	// Register offsets
	localparam logic [2:0] GST_OFS_COUNT_LOW = 3'h0;
	localparam logic [2:0] GST_OFS_COUNT_HIGH = 3'h1;
	localparam logic [2:0] GST_OFS_TIMER_CTRL = 3'h2;
	localparam logic [2:0] GST_OFS_GATE_CTRL = 3'h3;
	localparam logic [2:0] GST_OFS_INT_STATUS = 3'h4;
	localparam logic [2:0] GST_OFS_INT_MASK = 3'h5;

	// timer_control_reg fields
	localparam int GST_TC_SRC_LSB = 6;
	localparam int GST_TC_PRE_LSB = 4;
	localparam int GST_TC_OSC_EN = 3;
	localparam int GST_TC_ASYNC = 2;
	localparam int GST_TC_RUN = 0;
	localparam logic [7:0] GST_TC_WMASK = 8'hFD;

	// gate_control_reg fields
	localparam int GST_GC_GATE_EN = 7;
	localparam int GST_GC_GATE_POL = 6;
	localparam int GST_GC_GATE_VAL = 2;
	localparam logic [7:0] GST_GC_WMASK = 8'hC0;

	// Interrupt status and mask fields
	localparam int GST_IRQ_OVF = 0;
	localparam int GST_IRQ_SPEC = 1;
	localparam int GST_IRQ_N = 2;

	// Reset values
	localparam logic [15:0] GST_RST_COUNT = 16'h0000;
	localparam logic [7:0] GST_RST_TIMER_CTRL = 8'h00;
	localparam logic [7:0] GST_RST_GATE_CTRL = 8'h00;
	localparam logic [1:0] GST_RST_IRQ = 2'h0;

	// Instruction cycle is four system clocks
	localparam int GST_INSTR_DIV = 4;

	typedef enum logic [1:0] {
		GST_SRC_INSTR,
		GST_SRC_SYS,
		GST_SRC_EXT,
		GST_SRC_LF
	} gst_src_e;
endpackage
`default_nettype wire

// ### gst_sync.sv
// Two-or-more flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module gst_sync #(
	parameter int STAGES = 2
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_async,
	output logic o_sync
);
	logic [STAGES-1:0] chain;

	initial begin
		if (STAGES < 2) begin
			$error("gst_sync needs at least two stages");
		end
	end

	// Only the last stage leaves this module
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], i_async};
		end
	end

	assign o_sync = chain[STAGES-1];
endmodule
`default_nettype wire

// ### gst_timer.sv
// Gated sixteen-bit timer/counter with register port and interrupt
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// RQ1: Sixteen-bit up counter seen as two bytes; byte writes load it at once.
// RQ2: Internal source makes a timer stepping once per instruction cycle.
// RQ3: Run off stops; run on counts; with gate enable counts while gate allows.
// RQ4: Source field and crystal enable pick LF, crystal, pin, sysclk, sysclk/4.
// RQ5: Internal source ticks pass a two-bit prescaler before the counter.
// RQ6: Undivided system clock source advances four counts per instruction cycle.
// RQ7: External input counts on each rising edge once counting is enabled.
// RQ8: External input counted aligned to instruction cycle or at once.
// RQ9: Counter mode needs a falling edge after enable, write or disable.
// RQ10: Overflow wakes from sleep only with external clock in async mode.
// RQ11: Count is the capture/compare time base; special event trigger is accepted.
// RQ12: Rollover from all ones sets a sticky overflow flag until cleared.
// RQ13: Prescaler pulses reach the counter only when enabled and, with gate enable set, gate active.
module gst_timer #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [gst_pkg::GST_ADDR_W-1:0] i_addr,
	input wire logic [gst_pkg::GST_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [gst_pkg::GST_DATA_W-1:0] o_rdata,
	input wire logic i_ext_count_input,
	input wire logic i_crystal_in_pin,
	input wire logic i_low_freq_internal_osc,
	input wire logic i_gate_input_pin,
	input wire logic i_special_event,
	output logic [gst_pkg::GST_COUNT_W-1:0] o_time_base,
	output logic o_irq,
	output logic o_wake
);
	import gst_pkg::*;

	initial begin
		if (SYNC_STAGES < 2) begin
			$error("gst_timer needs at least two synchroniser stages");
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [15:0] count;
	logic [7:0] timer_control_reg;
	logic [7:0] gate_control_reg;
	logic [GST_IRQ_N-1:0] int_status;
	logic [GST_IRQ_N-1:0] int_mask;
	logic [1:0] instr_div;
	logic instr_tick;
	logic ext_sync;
	logic crystal_sync;
	logic lf_sync;
	logic gate_sync;
	logic ext_level;
	logic ext_prev;
	logic lf_prev;
	logic ext_armed;
	logic ext_pending;
	logic [2:0] pre_cnt;
	logic [2:0] pre_last;
	logic src_tick;
	logic pre_pulse;
	logic count_en;
	logic gate_active;
	logic step;
	logic wr_low;
	logic wr_high;
	logic byte_write;
	logic ext_src;
	logic ext_rise;
	logic ext_fall;
	logic lf_rise;
	logic ovf_event;
	logic spec_event;
	logic [7:0] next_rdata;
	gst_src_e src;
	logic run_enable;
	logic gate_enable;
	logic crystal_osc_enable;
	logic async_mode;
	logic [1:0] prescale;

	//////////////////////////////////////////////////////////////////////////
	// Field decode
	assign src = gst_src_e'(timer_control_reg[GST_TC_SRC_LSB+:2]);
	assign prescale = timer_control_reg[GST_TC_PRE_LSB+:2];
	assign crystal_osc_enable = timer_control_reg[GST_TC_OSC_EN];
	assign async_mode = timer_control_reg[GST_TC_ASYNC];
	assign run_enable = timer_control_reg[GST_TC_RUN];
	assign gate_enable = gate_control_reg[GST_GC_GATE_EN];

	assign wr_low = i_wr && (i_addr == GST_OFS_COUNT_LOW);
	assign wr_high = i_wr && (i_addr == GST_OFS_COUNT_HIGH);
	assign byte_write = wr_low || wr_high;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	gst_sync #(.STAGES(SYNC_STAGES)) u_sync_ext (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_ext_count_input),
		.o_sync(ext_sync)
	);

	gst_sync #(.STAGES(SYNC_STAGES)) u_sync_crystal (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_crystal_in_pin),
		.o_sync(crystal_sync)
	);

	gst_sync #(.STAGES(SYNC_STAGES)) u_sync_lf (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_low_freq_internal_osc),
		.o_sync(lf_sync)
	);

	gst_sync #(.STAGES(SYNC_STAGES)) u_sync_gate (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_gate_input_pin),
		.o_sync(gate_sync)
	);

	//////////////////////////////////////////////////////////////////////////
	// Instruction clock: one tick every four system clocks
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= instr_div + 2'h1;
		end
	end

	assign instr_tick = (instr_div == 2'(GST_INSTR_DIV - 1));

	//////////////////////////////////////////////////////////////////////////
	// Edge detection on the synchronised inputs
	// Crystal enable steers the external path between the two pins
	assign ext_level = crystal_osc_enable ? crystal_sync : ext_sync; // see RQ4
	assign ext_src = (src == GST_SRC_EXT);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ext_prev <= 1'b0;
			lf_prev <= 1'b0;
		end else begin
			ext_prev <= ext_level;
			lf_prev <= lf_sync;
		end
	end

	assign ext_rise = ext_level && !ext_prev; // see RQ7
	assign ext_fall = !ext_level && ext_prev;
	assign lf_rise = lf_sync && !lf_prev;

	// Disarmed while off or after a count write; a falling edge re-arms.
	// Also covers disabling high then enabling low, at the cost of
	// ignoring a falling edge seen while the timer was off.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ext_armed <= 1'b0;
		end else if (!run_enable || byte_write) begin
			ext_armed <= 1'b0; // see RQ9
		end else if (ext_fall) begin
			ext_armed <= 1'b1; // see RQ9
		end
	end

	// Synchronous mode holds an edge until the next instruction cycle
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ext_pending <= 1'b0;
		end else if (byte_write || async_mode) begin
			ext_pending <= 1'b0;
		end else if (instr_tick) begin
			// An edge on the tick itself is counted at once, so never held too
			ext_pending <= 1'b0;
		end else if (ext_rise && ext_armed) begin
			ext_pending <= 1'b1; // see RQ8
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Source selection
	always_comb begin
		src_tick = 1'b0;
		unique case (src)
			GST_SRC_INSTR: src_tick = instr_tick; // see RQ2
			GST_SRC_SYS: src_tick = 1'b1; // see RQ6
			GST_SRC_EXT: begin
				if (async_mode) begin
					src_tick = ext_rise && ext_armed; // see RQ8
				end else begin
					src_tick = instr_tick && (ext_pending || (ext_rise && ext_armed));
				end
			end
			GST_SRC_LF: src_tick = lf_rise; // see RQ4
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Enable and gate
	assign gate_active = gate_sync ^ !gate_control_reg[GST_GC_GATE_POL];
	assign count_en = run_enable && (!gate_enable || gate_active); // see RQ3

	//////////////////////////////////////////////////////////////////////////
	// Prescaler 1:1, 1:2, 1:4, 1:8
	assign pre_last = 3'((4'h1 << prescale) - 4'h1);
	assign pre_pulse = src_tick && (pre_cnt >= pre_last); // see RQ5

	// Held while disabled so a gated window starts from a clean phase
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || byte_write || !count_en) begin
			pre_cnt <= 3'h0;
		end else if (pre_pulse) begin
			pre_cnt <= 3'h0;
		end else if (src_tick) begin
			pre_cnt <= pre_cnt + 3'h1;
		end
	end

	assign step = pre_pulse && count_en; // see RQ13

	//////////////////////////////////////////////////////////////////////////
	// Counter
	assign spec_event = i_special_event;
	assign ovf_event = step && !byte_write && !spec_event && (count == 16'hFFFF);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			count <= GST_RST_COUNT;
		end else if (wr_low) begin
			count[7:0] <= i_wdata; // see RQ1
		end else if (wr_high) begin
			count[15:8] <= i_wdata; // see RQ1
		end else if (spec_event) begin
			count <= GST_RST_COUNT; // see RQ11
		end else if (step) begin
			count <= count + 16'h0001; // see RQ1
		end
	end

	// The live count is the capture/compare time base
	assign o_time_base = count; // see RQ11

	//////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			timer_control_reg <= GST_RST_TIMER_CTRL;
		end else if (i_wr && (i_addr == GST_OFS_TIMER_CTRL)) begin
			timer_control_reg <= i_wdata & GST_TC_WMASK;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			gate_control_reg <= GST_RST_GATE_CTRL;
		end else if (i_wr && (i_addr == GST_OFS_GATE_CTRL)) begin
			gate_control_reg <= i_wdata & GST_GC_WMASK;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Interrupts: a new event wins over a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			int_status <= GST_RST_IRQ;
		end else begin
			if (i_wr && (i_addr == GST_OFS_INT_STATUS)) begin
				int_status <= int_status & ~i_wdata[GST_IRQ_N-1:0];
			end
			if (ovf_event) begin
				int_status[GST_IRQ_OVF] <= 1'b1; // see RQ12
			end
			if (spec_event) begin
				int_status[GST_IRQ_SPEC] <= 1'b1; // see RQ11
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			int_mask <= GST_RST_IRQ;
		end else if (i_wr && (i_addr == GST_OFS_INT_MASK)) begin
			int_mask <= i_wdata[GST_IRQ_N-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(int_status & int_mask);
		end
	end

	// Only the async external path keeps running without the system clock
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= int_status[GST_IRQ_OVF] && int_mask[GST_IRQ_OVF] && ext_src
				&& async_mode; // see RQ10
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read port
	always_comb begin
		next_rdata = 8'h00;
		unique case (i_addr)
			GST_OFS_COUNT_LOW: next_rdata = count[7:0];
			GST_OFS_COUNT_HIGH: next_rdata = count[15:8];
			GST_OFS_TIMER_CTRL: next_rdata = timer_control_reg;
			GST_OFS_GATE_CTRL: begin
				next_rdata = gate_control_reg;
				next_rdata[GST_GC_GATE_VAL] = gate_active;
			end
			GST_OFS_INT_STATUS: next_rdata = {6'h00, int_status};
			GST_OFS_INT_MASK: next_rdata = {6'h00, int_mask};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### gst_timer_asserts.sv
// Port-level property checker for the gated sixteen-bit timer
`timescale 1ns/10ps
`default_nettype none
module gst_timer_asserts
	import gst_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [GST_ADDR_W-1:0] i_addr,
	input wire logic [GST_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [GST_DATA_W-1:0] o_rdata,
	input wire logic i_special_event,
	input wire logic [GST_COUNT_W-1:0] o_time_base,
	input wire logic o_irq,
	input wire logic o_wake
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	a_rdata_unmap: assert property ($past(i_rd) && $past(i_addr) > 3'h5 |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_low_write: assert property (i_wr && i_addr == GST_OFS_COUNT_LOW
		|=> o_time_base[7:0] == $past(i_wdata))
		else $error("low byte write not loaded");
	a_high_write: assert property (i_wr && i_addr == GST_OFS_COUNT_HIGH
		|=> o_time_base[15:8] == $past(i_wdata))
		else $error("high byte write not loaded");
	a_event_clear: assert property (i_special_event && !i_wr |=> o_time_base == 16'h0000)
		else $error("special event did not clear count");
	// Only +1 steps are legal when no bus write or event intervenes
	a_step_one: assert property (!$past(i_wr) && !$past(i_special_event) && $changed(o_time_base)
		|-> o_time_base == $past(o_time_base) + 16'h0001)
		else $error("count moved by other than one");
	a_wake_irq: assert property (o_wake |-> o_irq)
		else $error("wake without interrupt");
	a_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2))
		else $error("interrupt dropped without a write");
	c_wrap: cover property ($past(o_time_base) == 16'hFFFF && o_time_base == 16'h0000);
	c_wake: cover property ($rose(o_wake));
	c_irq: cover property ($rose(o_irq));
endmodule
bind gst_timer gst_timer_asserts #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.i_clk(i_clk),
	.i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_special_event(i_special_event), .o_time_base(o_time_base),
	.o_irq(o_irq), .o_wake(o_wake));
`default_nettype wire

// ### gst_pin_src.sv
// Model of the external count source and gate driver
`timescale 1ns/10ps
`default_nettype none
module gst_pin_src (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_n,
	input wire logic i_idle,
	input wire logic i_slow,
	input wire logic i_gate_lvl,
	output logic o_ext,
	output logic o_gate
);
	logic [4:0] left = 5'h00;
	logic [2:0] ph = 3'h0;
	initial o_ext = 1'b1;
	assign o_gate = i_gate_lvl;
	// Pulses leave idle and return, so an idle-low start shows a rise first
	always @(posedge i_clk) begin
		if (i_go) begin
			left <= {i_n, 1'b0};
			ph <= 3'h0;
		end else if (left != 5'h00) begin
			ph <= ph + 3'h1;
			if (ph == (i_slow ? 3'h5 : 3'h1)) begin
				ph <= 3'h0;
				left <= left - 5'h01;
				o_ext <= ~o_ext;
			end
		end else begin
			o_ext <= i_idle;
		end
	end
endmodule
`default_nettype wire

// ### test_gated_sixteen_bit_timer.sv
// Self-checking bench for the gated sixteen-bit timer
`timescale 1ns/10ps
`default_nettype none
module test_gated_sixteen_bit_timer;
	import gst_pkg::*;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_special_event = 1'b0;
	logic go = 1'b0;
	logic idle = 1'b1;
	logic slow = 1'b1;
	logic gate_lvl = 1'b1;
	logic rd_q = 1'b0;
	logic [3:0] n_pulse = 4'h0;
	logic [3:0] osc_cnt = 4'h0;
	logic [7:0] o_rdata;
	logic [15:0] o_time_base;
	logic o_irq;
	logic o_wake;
	logic ext_pin;
	logic gate_pin;
	logic [7:0] exp_q[$];
	logic [15:0] a;
	logic [7:0] rv;
	int n_fail = 0;
	int checks_done = 0;
	integer seed = 32'h867c;
	logic [7:0] cv [10] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h51, 8'h61, 8'h71, 8'hC1, 8'h89};
	logic [15:0] dv [10] = '{16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0040, 16'h0020,
		16'h0010, 16'h0008, 16'h0004, 16'h0008};
	gst_timer #(.SYNC_STAGES(2)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ext_count_input(ext_pin), .i_crystal_in_pin(osc_cnt[2]),
		.i_low_freq_internal_osc(osc_cnt[3]), .i_gate_input_pin(gate_pin),
		.i_special_event(i_special_event), .o_time_base(o_time_base), .o_irq(o_irq),
		.o_wake(o_wake));
	gst_pin_src u_src (.i_clk(i_clk), .i_go(go), .i_n(n_pulse), .i_idle(idle), .i_slow(slow),
		.i_gate_lvl(gate_lvl), .o_ext(ext_pin), .o_gate(gate_pin));
	initial forever #20 i_clk = ~i_clk;
	always @(posedge i_clk) osc_cnt <= osc_cnt + 4'h1;
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task print_verdict;
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input logic [2:0] ad, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task rd(input logic [2:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask
	task rate(input string nm, input logic [15:0] e);
		repeat (16) @(posedge i_clk);
		a = o_time_base;
		repeat (64) @(posedge i_clk);
		chk(nm, o_time_base - a, e);
	endtask
	task pulses(input logic [3:0] n, input logic s);
		go <= 1'b1;
		n_pulse <= n;
		slow <= s;
		@(posedge i_clk);
		go <= 1'b0;
		repeat (60) @(posedge i_clk);
	endtask
	// Read data is judged one cycle after its strobe, oldest note first
	always @(posedge i_clk) begin
		if (rd_q)
			chk("read data", {8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
		rd_q <= i_rd;
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		print_verdict;
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		for (int k = 0; k < 8; k++)
			rd(k[2:0], 8'h00);
		for (int k = 0; k < 4; k++) begin
			rv = $random(seed);
			wr(k[0] ? GST_OFS_COUNT_HIGH : GST_OFS_COUNT_LOW, rv);
			rd(k[0] ? GST_OFS_COUNT_HIGH : GST_OFS_COUNT_LOW, rv);
			wr(3'h6, rv);
			rd(3'h6, 8'h00);
		end
		wr(GST_OFS_TIMER_CTRL, 8'hFF);
		rd(GST_OFS_TIMER_CTRL, 8'hFD);
		wr(GST_OFS_GATE_CTRL, 8'hFF);
		rd(GST_OFS_GATE_CTRL, 8'hC4);
		wr(GST_OFS_GATE_CTRL, 8'h00);
		for (int k = 0; k < 10; k++) begin
			wr(GST_OFS_TIMER_CTRL, cv[k]);
			rate("count rate", dv[k]);
		end
		wr(GST_OFS_TIMER_CTRL, 8'h41);
		for (int k = 0; k < 4; k++) begin
			gate_lvl <= k[0];
			wr(GST_OFS_GATE_CTRL, k[1] ? 8'h80 : 8'hC0);
			rate("gated rate", (k[0] == !k[1]) ? 16'h0040 : 16'h0000);
		end
		wr(GST_OFS_GATE_CTRL, 8'h00);
		wr(GST_OFS_TIMER_CTRL, 8'h40);
		rate("stopped rate", 16'h0000);
		wr(GST_OFS_INT_MASK, 8'h01);
		wr(GST_OFS_COUNT_HIGH, 8'hFF);
		wr(GST_OFS_COUNT_LOW, 8'hF0);
		wr(GST_OFS_TIMER_CTRL, 8'h41);
		repeat (40) @(posedge i_clk);
		wr(GST_OFS_TIMER_CTRL, 8'h00);
		chk("irq", {15'h0000, o_irq}, 16'h0001);
		rd(GST_OFS_INT_STATUS, 8'h01);
		// The interrupt pin is registered one cycle behind status and mask
		wr(GST_OFS_INT_MASK, 8'h00);
		@(posedge i_clk);
		chk("irq", {15'h0000, o_irq}, 16'h0000);
		wr(GST_OFS_INT_MASK, 8'h01);
		@(posedge i_clk);
		chk("irq", {15'h0000, o_irq}, 16'h0001);
		wr(GST_OFS_INT_STATUS, 8'h01);
		@(posedge i_clk);
		chk("irq", {15'h0000, o_irq}, 16'h0000);
		rd(GST_OFS_INT_STATUS, 8'h00);
		i_special_event <= 1'b1;
		@(posedge i_clk);
		i_special_event <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("event clear", o_time_base, 16'h0000);
		rd(GST_OFS_INT_STATUS, 8'h02);
		wr(GST_OFS_INT_STATUS, 8'h02);
		// Async run may wake, the aligned run must not
		for (int k = 0; k < 2; k++) begin
			wr(GST_OFS_TIMER_CTRL, 8'h00);
			wr(GST_OFS_COUNT_LOW, 8'hFE);
			wr(GST_OFS_COUNT_HIGH, 8'hFF);
			wr(GST_OFS_TIMER_CTRL, k[0] ? 8'h85 : 8'h81);
			pulses(4'h3, !k[0]);
			chk("ext count", o_time_base, 16'h0001);
			chk("wake", {15'h0000, o_wake}, {15'h0000, k[0]});
			wr(GST_OFS_INT_STATUS, 8'h01);
		end
		wr(GST_OFS_TIMER_CTRL, 8'h00);
		idle <= 1'b0;
		repeat (8) @(posedge i_clk);
		wr(GST_OFS_COUNT_LOW, 8'h00);
		wr(GST_OFS_COUNT_HIGH, 8'h00);
		wr(GST_OFS_TIMER_CTRL, 8'h81);
		pulses(4'h3, 1'b1);
		chk("ext arm", o_time_base, 16'h0002);
		repeat (4) @(posedge i_clk);
		print_verdict;
	end
endmodule
`default_nettype wire
